// ---- shared/dac_load_pkg.sv ----
package dac_load_pkg;

  // frame and code layout
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 18;
  localparam int CODE_MSB = 17;
  localparam int CNT_W = 5;
  localparam logic [4:0] FRAME_FULL = 5'h18;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [23:0] INPUT_RESET = 24'h000000;

  // host side sizes
  localparam int TX_BITS = 96;
  localparam int LEN_W = 7;

  // timing, host clock 100 MHz
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 40;
  localparam int CS_GAP_NS = 100;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int CS_GAP_CYC = (CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TMR_W = 5;
  localparam logic [4:0] HALF_LOAD = 5'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] GAP_LOAD = 5'(CS_GAP_CYC - 1);

  // synchroniser vector positions in the device end
  localparam int SYNC_W = 4;
  localparam int SY_CS = 0;
  localparam int SY_LOAD = 1;
  localparam int SY_PD = 2;
  localparam int SY_SEL = 3;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_HIGH,
    H_LOW,
    H_HOLD,
    H_GAP
  } host_state_t;

endpackage

// ---- shared/dac_link_if.sv ----
`timescale 1ns/1ps
interface dac_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo_drv;
  logic sdo_oe;
  wire sdo_line;

  // released line reads high, as with a pull-up
  assign sdo_line = sdo_oe ? sdo_drv : 1'b1;

  modport device (
    input sclk,
    input cs_n,
    input sdi,
    output sdo_drv,
    output sdo_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output sdi,
    input sdo_line
  );
endinterface

// ---- verilog/bit_sync.sv ----
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // async levels in, synced levels out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // bit_sync

// ---- verilog/dac_device_end.sv ----
`timescale 1ns/1ps
// What this block does
// - power-down grounds output, registers keep values
// - power-down release drives output from latch
// - input register loads only on valid frame
// - load high holds latch, low passes through
// - load low: latch follows new input word
// - load high blocks; falling load copies input
// - chip select high: ignore link, release output
// - shift input on rising clock while selected
// - under 24 bits: frame invalid, keep values
// - over 24 bits: keep last 24 bits
// - bits 17..0 form code, upper six ignored
// - host sends most significant bit first
// - host raises select after the frame_bits-th rising edge
// - readback mode shifts input register out
// - readback past 24 clocks gives zeros
// - host keeps readback of short frames in rx word
// - chain mode ripples bits out, falling edge
// - chain: host sends 24 clocks per device
// - chain: select rise moves shift to input
// - shift register has no reset; select idles high
module dac_device_end (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // serial link, clocked by the host
  dac_link_if.device link,
  // control pins
  input wire logic power_down_pin_i,
  input wire logic latch_load_n_i,
  input wire logic readout_chain_select_i,
  // converter side
  output logic [dac_load_pkg::CODE_BITS-1:0] dac_code_o,
  output logic [dac_load_pkg::CODE_BITS-1:0] ladder_code_o,
  output logic output_grounded_o,
  output logic [dac_load_pkg::FRAME_BITS-1:0] input_word_o
);
  logic [dac_load_pkg::FRAME_BITS-1:0] shift_reg;
  logic [dac_load_pkg::CNT_W-1:0] bit_cnt_reg;
  logic started_reg;
  logic sdo_reg;
  logic sdo_next;
  logic fell_reg;
  logic first_bit;
  logic [dac_load_pkg::SYNC_W-1:0] pins_async;
  logic [dac_load_pkg::SYNC_W-1:0] pins_sync;
  logic cs_prev_reg;
  logic frame_end;
  logic [dac_load_pkg::FRAME_BITS-1:0] input_reg;
  logic [dac_load_pkg::CODE_BITS-1:0] latch_reg;
  logic pd_reg;
  logic chain_sel_reg;

  // link clock domain

  // no reset on purpose: contents survive reset
  always_ff @(posedge link.sclk)
  begin
    if (!link.cs_n)
    begin
      shift_reg <= {shift_reg[dac_load_pkg::FRAME_BITS-2:0], link.sdi};
    end
  end

  // cleared by select high since the clock stops between frames
  always_ff @(posedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      started_reg <= 1'b0;
    end
    else
    begin
      started_reg <= 1'b1;
    end
  end

  // count survives select rise so the system side can judge the frame
  always_ff @(posedge link.sclk)
  begin
    if (!link.cs_n)
    begin
      if (!started_reg)
      begin
        bit_cnt_reg <= dac_load_pkg::CNT_ONE;
      end
      else if (bit_cnt_reg != dac_load_pkg::FRAME_FULL)
      begin
        bit_cnt_reg <= bit_cnt_reg + dac_load_pkg::CNT_ONE;
      end
    end
  end

  // input_reg only moves after select rises, so it is stable here
  always_comb
  begin
    sdo_next = 1'b0;
    if (!chain_sel_reg)
    begin
      sdo_next = input_reg[dac_load_pkg::FRAME_BITS-1];
    end
    else
    begin
      sdo_next = shift_reg[dac_load_pkg::FRAME_BITS-1];
    end
    if (!chain_sel_reg && bit_cnt_reg < dac_load_pkg::FRAME_FULL)
    begin
      sdo_next = input_reg[5'(dac_load_pkg::FRAME_BITS - 1) - bit_cnt_reg];
    end
    else if (!chain_sel_reg)
    begin
      sdo_next = 1'b0;
    end
  end

  always_ff @(negedge link.sclk)
  begin
    if (!link.cs_n)
    begin
      sdo_reg <= sdo_next;
    end
  end

  // sdo_reg is stale until the first falling edge of a frame
  always_ff @(negedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      fell_reg <= 1'b0;
    end
    else
    begin
      fell_reg <= 1'b1;
    end
  end

  // before the first falling edge the top bit must already stand
  assign first_bit = chain_sel_reg ? shift_reg[dac_load_pkg::FRAME_BITS-1]
                                   : input_reg[dac_load_pkg::FRAME_BITS-1];
  assign link.sdo_drv = fell_reg ? sdo_reg : first_bit;
  assign link.sdo_oe = !link.cs_n;

  // system clock domain

  // select as active high: idle level matches the flushed synchroniser
  assign pins_async[dac_load_pkg::SY_CS] = !link.cs_n;
  assign pins_async[dac_load_pkg::SY_LOAD] = latch_load_n_i;
  assign pins_async[dac_load_pkg::SY_PD] = power_down_pin_i;
  assign pins_async[dac_load_pkg::SY_SEL] = readout_chain_select_i;

  bit_sync #(
    .WIDTH(dac_load_pkg::SYNC_W)
  ) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(pins_async),
    .q_o(pins_sync)
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cs_prev_reg <= 1'b0;
    end
    else
    begin
      cs_prev_reg <= pins_sync[dac_load_pkg::SY_CS];
    end
  end

  assign frame_end = !pins_sync[dac_load_pkg::SY_CS] && cs_prev_reg;

  // strap treated as static; read by the link side without resync
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      chain_sel_reg <= 1'b0;
    end
    else
    begin
      chain_sel_reg <= !pins_sync[dac_load_pkg::SY_SEL];
    end
  end

  // shift word and count are frozen while select is high
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      input_reg <= dac_load_pkg::INPUT_RESET;
    end
    else if (frame_end && bit_cnt_reg == dac_load_pkg::FRAME_FULL)
    begin
      input_reg <= shift_reg;
    end
  end

  // copy one cycle behind the input register
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      latch_reg <= dac_load_pkg::INPUT_RESET[dac_load_pkg::CODE_MSB:0];
    end
    else if (!pins_sync[dac_load_pkg::SY_LOAD])
    begin
      latch_reg <= input_reg[dac_load_pkg::CODE_MSB:0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      pd_reg <= 1'b0;
    end
    else
    begin
      pd_reg <= pins_sync[dac_load_pkg::SY_PD];
    end
  end

  // ladder code decodes the synced pin, as pd_reg does, to keep grounding and code aligned
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ladder_code_o <= '0;
    end
    else if (pins_sync[dac_load_pkg::SY_PD])
    begin
      ladder_code_o <= '0;
    end
    else
    begin
      ladder_code_o <= latch_reg;
    end
  end

  assign dac_code_o = latch_reg;
  assign output_grounded_o = pd_reg;
  assign input_word_o = input_reg;
endmodule // dac_device_end

// ---- verilog/dac_host_end.sv ----
`timescale 1ns/1ps
module dac_host_end (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // serial link, clock made here
  dac_link_if.host link,
  // user request
  input wire logic start_i,
  input wire logic [dac_load_pkg::TX_BITS-1:0] tx_word_i,
  input wire logic [dac_load_pkg::LEN_W-1:0] frame_bits_i,
  // user answer
  output logic busy_o,
  output logic done_o,
  output logic [dac_load_pkg::FRAME_BITS-1:0] rx_word_o
);
  dac_load_pkg::host_state_t state_reg;
  logic [dac_load_pkg::TX_BITS-1:0] tx_reg;
  logic [dac_load_pkg::LEN_W-1:0] len_reg;
  logic [dac_load_pkg::LEN_W-1:0] sent_reg;
  logic [dac_load_pkg::TMR_W-1:0] tmr_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic sdi_reg;
  logic sdo_sync;
  logic tmr_done;
  logic [dac_load_pkg::TX_BITS-1:0] tx_aligned;

  bit_sync #(
    .WIDTH(1)
  ) u_sdo_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(link.sdo_line),
    .q_o(sdo_sync)
  );

  assign tmr_done = (tmr_reg == '0);
  // last frame_bits bits go out, most significant first
  assign tx_aligned = tx_word_i << (7'(dac_load_pkg::TX_BITS) - frame_bits_i);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_reg <= dac_load_pkg::H_IDLE;
      tmr_reg <= '0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sdi_reg <= 1'b0;
      tx_reg <= '0;
      len_reg <= '0;
      sent_reg <= '0;
      done_o <= 1'b0;
      rx_word_o <= '0;
      busy_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (!tmr_done)
      begin
        tmr_reg <= tmr_reg - 5'h01;
      end
      unique case (state_reg)
        dac_load_pkg::H_IDLE:
        begin
          if (start_i)
          begin
            cs_n_reg <= 1'b0;
            busy_o <= 1'b1;
            tx_reg <= tx_aligned;
            sdi_reg <= tx_aligned[dac_load_pkg::TX_BITS-1];
            len_reg <= frame_bits_i;
            sent_reg <= '0;
            tmr_reg <= dac_load_pkg::HALF_LOAD;
            state_reg <= dac_load_pkg::H_SETUP;
          end
        end
        dac_load_pkg::H_SETUP, dac_load_pkg::H_LOW:
        begin
          if (tmr_done)
          begin
            sclk_reg <= 1'b1;
            tmr_reg <= dac_load_pkg::HALF_LOAD;
            state_reg <= dac_load_pkg::H_HIGH;
          end
        end
        dac_load_pkg::H_HIGH:
        begin
          if (tmr_done)
          begin
            // device output settled a full half period ago
            rx_word_o <= {rx_word_o[dac_load_pkg::FRAME_BITS-2:0], sdo_sync};
            sent_reg <= sent_reg + 7'h01;
            sclk_reg <= 1'b0;
            tmr_reg <= dac_load_pkg::HALF_LOAD;
            if (sent_reg + 7'h01 == len_reg)
            begin
              state_reg <= dac_load_pkg::H_HOLD;
            end
            else
            begin
              tx_reg <= {tx_reg[dac_load_pkg::TX_BITS-2:0], 1'b0};
              sdi_reg <= tx_reg[dac_load_pkg::TX_BITS-2];
              state_reg <= dac_load_pkg::H_LOW;
            end
          end
        end
        dac_load_pkg::H_HOLD:
        begin
          if (tmr_done)
          begin
            cs_n_reg <= 1'b1;
            tmr_reg <= dac_load_pkg::GAP_LOAD;
            state_reg <= dac_load_pkg::H_GAP;
          end
        end
        dac_load_pkg::H_GAP:
        begin
          if (tmr_done)
          begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state_reg <= dac_load_pkg::H_IDLE;
          end
        end
        default:
        begin
          state_reg <= dac_load_pkg::H_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sdi = sdi_reg;
endmodule // dac_host_end

// ---- sim/dac_link_properties.sv ----
`timescale 1ns/1ps
module dac_link_properties (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // link wires
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic sdo_drv_i,
  input wire logic sdo_oe_i,
  input wire logic sdo_line_i
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sdo_release_a: assert property (cs_n_i |-> !sdo_oe_i)
    else $error("sdo driven while deselected");
  sdo_drive_a: assert property ($fell(cs_n_i) |-> ##[0:2] sdo_oe_i)
    else $error("sdo not driven in frame");
  cs_edge_a: assert property ($changed(cs_n_i) |-> !sclk_i)
    else $error("select moved with clock high");
  sclk_idle_a: assert property (cs_n_i |-> !sclk_i)
    else $error("clock runs outside frame");
  high_width_a: assert property ($rose(sclk_i) |-> sclk_i [*4] ##1 !sclk_i)
    else $error("clock high phase wrong");
  low_width_a: assert property ($fell(sclk_i) |-> !sclk_i [*4])
    else $error("clock low phase too short");
  sdi_hold_a: assert property (sclk_i && $past(sclk_i) |-> $stable(sdi_i))
    else $error("sdi moved in high phase");
  sdo_hold_a: assert property (sclk_i && $past(sclk_i) && sdo_oe_i |-> $stable(sdo_drv_i))
    else $error("sdo moved in high phase");
  cs_gap_a: assert property ($rose(cs_n_i) |-> cs_n_i [*4])
    else $error("select gap too short");

  // main scenarios reached
  cover property ($rose(cs_n_i));
  cover property (!cs_n_i && sdo_oe_i && !sdo_line_i);
  cover property ($fell(sclk_i) && !cs_n_i);
endmodule // dac_link_properties

// ---- sim/dac_serial_load_control_tb_top.sv ----
`timescale 1ns/1ps
module dac_serial_load_control_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic start = 1'b0;
  logic [95:0] tx_word = '0;
  logic [6:0] frame_bits = 7'h18;
  logic pd = 1'b0;
  logic load_n = 1'b0;
  logic sel = 1'b1;
  logic done;
  logic busy;
  logic [23:0] rx_word;
  logic [23:0] input_word;
  logic [17:0] dac_code;
  logic [17:0] ladder_code;
  logic grounded;
  logic [23:0] exp_in = 24'h000000;
  int errors = 0;
  int check_count = 0;

  dac_link_if link_bus();

  dac_host_end i_dac_host_end (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link_bus), .start_i(start),
    .tx_word_i(tx_word), .frame_bits_i(frame_bits), .busy_o(busy), .done_o(done),
    .rx_word_o(rx_word));

  dac_device_end i_dac_device_end (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link_bus), .power_down_pin_i(pd),
    .latch_load_n_i(load_n), .readout_chain_select_i(sel), .dac_code_o(dac_code),
    .ladder_code_o(ladder_code), .output_grounded_o(grounded), .input_word_o(input_word));

  dac_link_properties i_dac_link_properties (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(link_bus.sclk), .cs_n_i(link_bus.cs_n),
    .sdi_i(link_bus.sdi), .sdo_drv_i(link_bus.sdo_drv), .sdo_oe_i(link_bus.sdo_oe),
    .sdo_line_i(link_bus.sdo_line));

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (errors == 0 && check_count > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // settle over the pin synchronisers
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic send(input logic [6:0] n, input logic [95:0] w);
    idle(1);
    frame_bits = n;
    tx_word = w;
    start = 1'b1;
    idle(1);
    start = 1'b0;
    check("busy", {23'h000000, busy}, 24'h1);
    while (done !== 1'b1)
      idle(1);
    check("busy end", {23'h000000, busy}, 24'h0);
    idle(4);
  endtask

  task automatic t_write;
    send(7'h18, 96'hFD5A3C);
    check("readback", rx_word, exp_in);
    exp_in = 24'hFD5A3C;
    check("input", input_word, exp_in);
    check("latch", dac_code, 24'h015A3C);
    check("ladder", ladder_code, 24'h015A3C);
    check("sdo idle", {link_bus.sdo_oe, link_bus.sdo_line}, 24'h1);
  endtask

  task automatic t_short;
    // readback of a short frame is not judged
    send(7'h0A, 96'h3FF);
    check("short input", input_word, exp_in);
    check("short latch", dac_code, {6'h00, exp_in[17:0]});
  endtask

  task automatic t_long;
    send(7'h1E, 96'h2BCD1234);
    check("long readback", rx_word, {exp_in[17:0], 6'h00});
    exp_in = 24'hCD1234;
    check("long input", input_word, exp_in);
  endtask

  task automatic t_async;
    load_n = 1'b1;
    idle(4);
    send(7'h18, 96'h0A5A5A);
    check("held latch", dac_code, 24'h011234);
    check("async input", input_word, 24'h0A5A5A);
    load_n = 1'b0;
    idle(6);
    check("loaded latch", dac_code, 24'h025A5A);
  endtask

  task automatic t_power;
    pd = 1'b1;
    idle(6);
    check("grounded", grounded, 24'h1);
    check("pd ladder", ladder_code, 24'h0);
    check("pd latch", dac_code, 24'h025A5A);
    send(7'h18, 96'h012345);
    check("pd ladder held", ladder_code, 24'h0);
    check("pd input", input_word, 24'h012345);
    pd = 1'b0;
    idle(6);
    check("released", grounded, 24'h0);
    check("ladder back", ladder_code, 24'h012345);
  endtask

  // two words through one device: the first falls out on sdo
  task automatic t_chain;
    sel = 1'b0;
    idle(4);
    send(7'h30, 96'h13579B2468AC);
    check("chain out", rx_word, 24'h13579B);
    check("chain input", input_word, 24'h2468AC);
    sel = 1'b1;
    idle(4);
  endtask

  initial
  begin
    #200000;
    errors++;
    test_done();
  end

  initial
  begin
    idle(4);
    rst_i = 1'b0;
    idle(6);
    t_write();
    t_short();
    t_long();
    t_async();
    t_power();
    t_chain();
    test_done();
  end
endmodule // dac_serial_load_control_tb_top
